// [shared/lpa_pkg.sv]
package lpa_pkg;
   // ==========================================
   // Command and indication codes, widths, FIFO depth and S enable reset value.
   localparam logic [3:0] CMD_DEACT_CONFIRM  = 4'hf;
   localparam logic [3:0] CMD_U_ONLY_REQ     = 4'h7;
   localparam logic [3:0] CMD_ACT_REQ        = 4'h8;
   localparam logic [3:0] IND_IDLE           = 4'hf;
   localparam logic [3:0] IND_U_ONLY_ACT     = 4'h7;
   localparam logic [3:0] IND_ACT_REQ        = 4'h8;
   localparam logic [3:0] IND_ACT            = 4'hc;
   localparam int         CODE_W             = 4;
   localparam int         DATA_W             = 8;
   localparam int         FIFO_DEPTH         = 32;
   localparam logic       S_ENABLE_RESET     = 1'b0;

   typedef enum logic [2:0] {
      LPA_IDLE,
      LPA_U_ACTIVE,
      LPA_TE_PENDING,
      LPA_S_ACTIVATING,
      LPA_FULL_ACTIVE
   } lpa_state_t;
endpackage

// [logic/lpa_fifo.sv]
`timescale 1ns/1ps
module lpa_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input  wire logic             mclk,
   input  wire logic             srst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   wire              do_wr = in_valid && in_ready;
   wire              do_rd = out_valid && out_ready;

   assign in_ready  = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data  = mem[rd_ptr];

   always_ff @(posedge mclk) begin
      if (do_wr) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (do_wr) wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         if (do_rd) rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
      end
   end
endmodule

// [logic/lpa_control.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - Last command U-only request: terminal activation waits for exchange activation request.
// - Deactivation confirm applied: terminal activations complete without exchange confirmation.
// - During partial activation user data passes transparently downstream.
// - Exchange gave up control: terminal activation completes unconfirmed.
// - With U active, activation request sets the S-activation enable bit.
module lpa_control
   import lpa_pkg::*;
#(
   parameter int DATA_W_P = lpa_pkg::DATA_W,
   parameter int DEPTH_P  = lpa_pkg::FIFO_DEPTH
) (
   input  wire logic                        mclk,
   input  wire logic                        srst,
   input  wire logic [lpa_pkg::CODE_W-1:0]  downstream_cmd,
   input  wire logic                        u_line_ready,
   input  wire logic                        terminal_activity_bit,
   input  wire logic                        terminal_active,
   output logic      [lpa_pkg::CODE_W-1:0]  upstream_ind,
   output logic                             s_activation_enable_bit,
   output logic                             downstream_transparent_signal,
   input  wire logic [DATA_W_P-1:0]         user_data,
   input  wire logic                        user_valid,
   output logic                             user_ready,
   output logic      [DATA_W_P-1:0]         line_data,
   output logic                             line_valid,
   input  wire logic                        line_ready
);
   import lpa_pkg::*;

   // ==========================================
   // Command decoding.
   lpa_state_t state;
   lpa_state_t next_state;
   logic       exch_released;
   wire        cmd_dc  = (downstream_cmd == CMD_DEACT_CONFIRM);
   wire        cmd_uar = (downstream_cmd == CMD_U_ONLY_REQ);
   wire        cmd_ar  = (downstream_cmd == CMD_ACT_REQ);
   wire        u_up    = (state != LPA_IDLE);
   wire        te_go   = exch_released || cmd_dc || cmd_ar;

   // ==========================================
   // Activation state machine.
   always_comb begin
      next_state = state;
      case (state)
         LPA_IDLE:         if (cmd_uar && u_line_ready) next_state = LPA_U_ACTIVE;
         LPA_U_ACTIVE: begin
            if (cmd_ar) next_state = LPA_S_ACTIVATING;
            else if (terminal_activity_bit) next_state = te_go ? LPA_S_ACTIVATING : LPA_TE_PENDING;
         end
         LPA_TE_PENDING:   if (te_go) next_state = LPA_S_ACTIVATING;
         LPA_S_ACTIVATING: if (terminal_active) next_state = LPA_FULL_ACTIVE;
         LPA_FULL_ACTIVE:  next_state = LPA_FULL_ACTIVE;
         default:          next_state = LPA_IDLE;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         state <= LPA_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // The latest of U_ONLY_ACTIVATION_REQUEST or DC (a DC counts only once U is up) decides who owns terminal activation.
   always_ff @(posedge mclk) begin
      if (srst) begin
         exch_released <= 1'b0;
      end else if (u_up && cmd_dc) begin
         exch_released <= 1'b1;
      end else if (cmd_uar) begin
         exch_released <= 1'b0;
      end
   end

   // ==========================================
   // Upstream indications and S enable.
   always_ff @(posedge mclk) begin
      if (srst) begin
         upstream_ind            <= IND_IDLE;
         s_activation_enable_bit <= S_ENABLE_RESET;
      end else begin
         s_activation_enable_bit <= (next_state == LPA_S_ACTIVATING) || (next_state == LPA_FULL_ACTIVE);
         case (next_state)
            LPA_U_ACTIVE:     upstream_ind <= IND_U_ONLY_ACT;
            LPA_TE_PENDING:   upstream_ind <= IND_ACT_REQ;
            LPA_S_ACTIVATING: upstream_ind <= IND_U_ONLY_ACT;
            LPA_FULL_ACTIVE:  upstream_ind <= IND_ACT;
            default:          upstream_ind <= IND_IDLE;
         endcase
      end
   end

   // ==========================================
   // Transparent user data path.
   logic fifo_in_ready;
   assign downstream_transparent_signal = u_up;
   assign user_ready = fifo_in_ready && u_up;

   lpa_fifo #(.WIDTH(DATA_W_P), .DEPTH(DEPTH_P)) u_fifo (
      .mclk      (mclk),
      .srst      (srst),
      .in_data   (user_data),
      .in_valid  (user_valid && u_up),
      .in_ready  (fifo_in_ready),
      .out_data  (line_data),
      .out_valid (line_valid),
      .out_ready (line_ready)
   );

   // ==========================================
   // Checks.
   property p_pending_holds;
      @(posedge mclk) disable iff (srst)
      (state == LPA_TE_PENDING && !exch_released && !cmd_ar && !cmd_dc) |=> (state == LPA_TE_PENDING);
   endproperty
   a_pending_holds: assert property (p_pending_holds) else $error("Pending activation left unconfirmed.");

   property p_dc_completes;
      @(posedge mclk) disable iff (srst)
      (state == LPA_U_ACTIVE && cmd_dc && terminal_activity_bit) |=> (state == LPA_S_ACTIVATING);
   endproperty
   a_dc_completes: assert property (p_dc_completes) else $error("Released activation did not proceed.");

   property p_released_proceeds;
      @(posedge mclk) disable iff (srst)
      (state == LPA_U_ACTIVE && exch_released && terminal_activity_bit) |=> (state == LPA_S_ACTIVATING);
   endproperty
   a_released_proceeds: assert property (p_released_proceeds) else $error("Released pending stalled.");

   property p_ar_sets_s;
      @(posedge mclk) disable iff (srst)
      (state == LPA_U_ACTIVE && cmd_ar) |=> s_activation_enable_bit;
   endproperty
   a_ar_sets_s: assert property (p_ar_sets_s) else $error("S enable not set after request.");

   property p_transparent;
      @(posedge mclk) disable iff (srst)
      (state == LPA_U_ACTIVE) |-> downstream_transparent_signal;
   endproperty
   a_transparent: assert property (p_transparent) else $error("Data path not transparent.");

   property p_data_passes;
      @(posedge mclk) disable iff (srst)
      (user_valid && user_ready) |=> line_valid;
   endproperty
   a_data_passes: assert property (p_data_passes) else $error("Accepted word not offered downstream.");

   sequence s_partial_done;
      (state == LPA_IDLE) ##1 (state == LPA_U_ACTIVE);
   endsequence
   property p_uai;
      @(posedge mclk) disable iff (srst)
      s_partial_done |-> (upstream_ind == IND_U_ONLY_ACT);
   endproperty
   a_uai: assert property (p_uai) else $error("U-only indication missing.");

   property p_ai;
      @(posedge mclk) disable iff (srst)
      (state == LPA_S_ACTIVATING && terminal_active) |=> (upstream_ind == IND_ACT);
   endproperty
   a_ai: assert property (p_ai) else $error("Activation indication missing.");

   property p_release_latch;
      @(posedge mclk) disable iff (srst)
      (u_up && cmd_dc) |=> exch_released;
   endproperty
   a_release_latch: assert property (p_release_latch) else $error("Release not recorded.");
endmodule

// [testbench/lpa_exchange_model.sv]
`timescale 1ns/1ps
// ==========================================
// Exchange controller model: partial activation, then keeps or gives up control.
module lpa_exchange_model
   import lpa_pkg::*;
(
   input  wire logic                       mclk,
   input  wire logic                       srst,
   input  wire logic [lpa_pkg::CODE_W-1:0] upstream_ind,
   input  wire logic                       start,
   input  wire logic                       release_ctl,
   input  wire logic                       exch_act,
   output logic      [lpa_pkg::CODE_W-1:0] downstream_cmd
);
   logic [2:0] wait_cnt;
   always_ff @(posedge mclk) begin
      if (srst || !start) begin
         downstream_cmd <= CMD_DEACT_CONFIRM;
         wait_cnt       <= 3'h0;
      end else if (downstream_cmd == CMD_DEACT_CONFIRM && upstream_ind == IND_IDLE) begin
         downstream_cmd <= CMD_U_ONLY_REQ;
      end else if (upstream_ind == IND_U_ONLY_ACT && release_ctl) begin
         downstream_cmd <= CMD_DEACT_CONFIRM;
      end else if (upstream_ind == IND_U_ONLY_ACT && exch_act) begin
         downstream_cmd <= CMD_ACT_REQ;
      end else if (upstream_ind == IND_ACT_REQ && !release_ctl) begin
         wait_cnt <= wait_cnt + 3'h1;
         if (wait_cnt == 3'h5) begin
            downstream_cmd <= CMD_ACT_REQ;
         end
      end
   end
endmodule

// [testbench/test_lt_partial_activation_control.sv]
`timescale 1ns/1ps
// ==========================================
// Bench for the activation control block.
module test_lt_partial_activation_control;
   import lpa_pkg::*;
   logic        mclk = 1'b0, srst = 1'b1, u_line_ready = 1'b0, start = 1'b0, release_ctl = 1'b0, exch_act = 1'b0;
   logic        terminal_activity_bit = 1'b0, terminal_active = 1'b0, user_valid = 1'b0, line_ready = 1'b0;
   logic        s_activation_enable_bit, downstream_transparent_signal, user_ready, line_valid;
   logic [3:0]  downstream_cmd, upstream_ind;
   logic [7:0]  user_data = 8'h00, line_data;
   logic [15:0] rnd = 16'hdcbe;
   logic [7:0]  q[$];
   int          bad_count = 0, compares = 0, n;

   lpa_control uut (.mclk(mclk), .srst(srst), .downstream_cmd(downstream_cmd), .u_line_ready(u_line_ready),
      .terminal_activity_bit(terminal_activity_bit), .terminal_active(terminal_active),
      .upstream_ind(upstream_ind), .s_activation_enable_bit(s_activation_enable_bit),
      .downstream_transparent_signal(downstream_transparent_signal), .user_data(user_data),
      .user_valid(user_valid), .user_ready(user_ready), .line_data(line_data), .line_valid(line_valid),
      .line_ready(line_ready));
   lpa_exchange_model exch (.mclk(mclk), .srst(srst), .upstream_ind(upstream_ind), .start(start),
      .release_ctl(release_ctl), .exch_act(exch_act), .downstream_cmd(downstream_cmd));

   initial forever #2.5 mclk = ~mclk;
   initial begin
      #100000;
      bad_count++;
      finish_test();
   end

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task finish_test();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task wait_for(input logic sel, input logic [3:0] want);
      for (n = 0; n < 60; n++) begin
         @(negedge mclk);
         if ((sel ? {3'h0, s_activation_enable_bit} : upstream_ind) === want) break;
      end
   endtask
   task activate(input logic rel, input logic ex);
      @(posedge mclk);
      srst <= 1'b1;
      start <= 1'b0;
      u_line_ready <= 1'b0;
      terminal_activity_bit <= 1'b0;
      terminal_active <= 1'b0;
      release_ctl <= rel;
      exch_act <= ex;
      repeat (9) @(posedge mclk);
      srst <= 1'b0;
      @(negedge mclk);
      check(upstream_ind, IND_IDLE, "reset ind");
      check(s_activation_enable_bit, S_ENABLE_RESET, "reset s enable");
      check(downstream_transparent_signal, 1'b0, "reset transparent");
      check(user_ready, 1'b0, "reset user ready");
      @(posedge mclk);
      u_line_ready <= 1'b1;
      start <= 1'b1;
      wait_for(1'b0, IND_U_ONLY_ACT);
      check(upstream_ind, IND_U_ONLY_ACT, "u only ind");
      check(downstream_transparent_signal, 1'b1, "transparent");
   endtask

   initial begin
      activate(1'b0, 1'b0);
      @(posedge mclk);
      rnd = lfsr(rnd);
      user_data <= rnd[7:0];
      user_valid <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(negedge mclk);
         if (user_ready !== 1'b1) break;
         q.push_back(user_data);
         @(posedge mclk);
         rnd = lfsr(rnd);
         user_data <= rnd[7:0];
      end
      @(posedge mclk);
      user_valid <= 1'b0;
      check(8'(q.size()), 8'(FIFO_DEPTH), "fifo fill");
      for (n = 0; n < 400 && q.size() > 0; n++) begin
         @(posedge mclk);
         rnd = lfsr(rnd);
         line_ready <= rnd[0];
         @(negedge mclk);
         if (line_valid === 1'b1 && line_ready) check(line_data, q.pop_front(), "line data");
      end
      check(8'(q.size()), 8'h00, "words left");
      @(posedge mclk);
      terminal_activity_bit <= 1'b1;
      wait_for(1'b0, IND_ACT_REQ);
      check(s_activation_enable_bit, 1'b0, "s enable while pending");
      wait_for(1'b1, 4'h1);
      check(s_activation_enable_bit, 1'b1, "s enable after request");
      @(posedge mclk);
      terminal_active <= 1'b1;
      wait_for(1'b0, IND_ACT);
      check(upstream_ind, IND_ACT, "active ind");
      activate(1'b1, 1'b0);
      repeat (4) @(posedge mclk);
      terminal_activity_bit <= 1'b1;
      wait_for(1'b1, 4'h1);
      check(s_activation_enable_bit, 1'b1, "s enable released");
      @(posedge mclk);
      terminal_active <= 1'b1;
      wait_for(1'b0, IND_ACT);
      check(upstream_ind, IND_ACT, "active ind released");
      activate(1'b0, 1'b1);
      wait_for(1'b1, 4'h1);
      check(s_activation_enable_bit, 1'b1, "s enable exchange request");
      @(posedge mclk);
      terminal_active <= 1'b1;
      wait_for(1'b0, IND_ACT);
      check(upstream_ind, IND_ACT, "active ind exchange request");
      finish_test();
   end
endmodule
